// ---- rtl/obl_loader.sv ----
// Purpose: Fetch the five option bytes after reset and decode them for the chip.
// Assumes: Flash answers each read or write with a one-cycle ack, a cycle or more later.
// Notes:   Registers are read over a plain port; of the option bytes only the mode byte accepts a write.
//
// The strobed register port was decided locally.

`timescale 1ns/1ps
`default_nettype none

module obl_loader
   import obl_pkg::*;
(
   input  wire logic        i_sys_clk,        // System clock, 50 MHz.
   input  wire logic        i_arst_n,         // Asynchronous reset, active low.
   input  wire logic        i_boot_swap,      // Boot swap active.
   input  wire logic        i_ext_prog,       // External dedicated programmer attached.
   input  wire logic        i_vdd_above_hi,   // Supply above upper threshold.
   input  wire logic        i_vdd_above_lo,   // Supply above lower threshold.
   output var  logic        o_flash_rd_q,     // Flash read pulse.
   output var  logic        o_flash_wr_q,     // Flash write pulse.
   output var  logic [15:0] o_flash_addr_q,   // Flash byte address.
   output var  logic [7:0]  o_flash_wdata_q,  // Flash write data.
   input  wire logic        i_flash_ack,      // Flash access complete.
   input  wire logic [7:0]  i_flash_rdata,    // Read data, valid with ack.
   input  wire logic [7:0]  i_addr,           // Register address.
   input  wire logic [7:0]  i_wdata,          // Register write data.
   input  wire logic        i_wr,             // Register write strobe.
   input  wire logic        i_rd,             // Register read strobe.
   output var  logic [7:0]  o_rdata_q,        // Register read data.
   output var  logic        o_cfg_valid_q,    // Decoded settings valid.
   output var  logic        o_lso_stoppable_q,// Software may stop low-speed oscillator.
   output var  logic        o_lso_stop_q,     // Low-speed oscillator stop command.
   output var  logic [2:0]  o_wdt_time_q,     // Watchdog overflow time code.
   output var  logic        o_wdt_en_q,       // Watchdog counter enable.
   output var  logic [1:0]  o_wdt_window_q,   // Watchdog window period code.
   output var  logic        o_poc_dual_q,     // Dual threshold mode selected.
   output var  logic        o_dbg_en_q,       // On-chip debug enabled.
   output var  logic        o_dbg_erase_q,    // Erase flash on failed debug auth.
   output var  logic        o_supply_reset_q  // Supply reset hold.
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   obl_state_t state_q;
   logic [2:0] idx_q;        // Byte being fetched.
   logic       swap_q;       // Boot swap caught at fetch start.
   logic       done_q;       // Fetch complete.
   logic       wr_rej_q;     // Refused mode write seen.
   logic       lso_req_q;    // Control bit from software.
   logic [7:0] byte_q [5];   // Shadow option bytes.
   logic [4:0] load_en;      // Per-byte capture strobes.
   logic       prog_wr;      // Accepted programmer write of the mode byte.
   logic       rej_wr;       // Refused write of the mode byte.
   logic [1:0] dbg_code;

   assign dbg_code = byte_q[OBL_IDX_DBG][OBL_F_DBG_HI:OBL_F_DBG_LO];

   assign prog_wr = i_wr && (i_addr == OBL_REG_POC) && i_ext_prog && (state_q == OBL_ST_DONE);
   assign rej_wr  = i_wr && (i_addr == OBL_REG_POC) && !prog_wr;

   // ----------------------------------------------------------------
   // Shadow bytes
   // ----------------------------------------------------------------
   // One load strobe per byte; a byte is only ever written by its own read.
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_byte
         assign load_en[g] = (state_q == OBL_ST_WAIT) && i_flash_ack && (idx_q == 3'(g));
         obl_hold_reg #(.W(8), .RST(OBL_BYTE_RST)) u_byte (
            .i_sys_clk (i_sys_clk),
            .i_arst_n  (i_arst_n),
            .i_load    (load_en[g]),
            .i_d       (i_flash_rdata),
            .o_q       (byte_q[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Fetch sequencer
   // ----------------------------------------------------------------
   // Automatic fetch.
   // The sequence restarts only through reset, so settings never change mid-run.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= OBL_ST_START;
         idx_q   <= 3'h0;
         swap_q  <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         case (state_q)
            OBL_ST_START: begin
               swap_q  <= i_boot_swap;
               idx_q   <= 3'h0;
               state_q <= OBL_ST_RD;
            end
            OBL_ST_RD: begin
               state_q <= OBL_ST_WAIT;
            end
            OBL_ST_WAIT: begin
               if (i_flash_ack) begin
                  if (idx_q == OBL_IDX_LAST) begin
                     state_q <= swap_q ? OBL_ST_COPY : OBL_ST_DONE;
                     done_q  <= !swap_q;
                  end else begin
                     idx_q   <= idx_q + 3'h1;
                     state_q <= OBL_ST_RD;
                  end
               end
            end
            OBL_ST_COPY: begin
               state_q <= OBL_ST_COPY_WAIT;
            end
            OBL_ST_COPY_WAIT: begin
               if (i_flash_ack) begin
                  state_q <= OBL_ST_DONE;
                  done_q  <= 1'b1;
               end
            end
            OBL_ST_PROG_WAIT: begin
               if (i_flash_ack) begin
                  state_q <= OBL_ST_DONE;
               end
            end
            OBL_ST_DONE: begin
               if (prog_wr) begin
                  state_q <= OBL_ST_PROG_WAIT;
               end
            end
            default: begin
               state_q <= OBL_ST_START;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Flash request port
   // ----------------------------------------------------------------
   // Area select.
   // Mode byte copy.
   // Programmer writes carry only bit 0 so stray upper bits never reach flash.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_flash_rd_q    <= 1'b0;
         o_flash_wr_q    <= 1'b0;
         o_flash_addr_q  <= 16'h0000;
         o_flash_wdata_q <= 8'h00;
      end else begin
         o_flash_rd_q <= (state_q == OBL_ST_RD);
         o_flash_wr_q <= (state_q == OBL_ST_COPY) || prog_wr;
         if (state_q == OBL_ST_RD) begin
            o_flash_addr_q <= (swap_q ? OBL_ALT_BASE : OBL_PRI_BASE) | {13'h0000, idx_q};
         end else if (state_q == OBL_ST_COPY) begin
            o_flash_addr_q  <= OBL_POC_PRI;
            o_flash_wdata_q <= byte_q[OBL_IDX_POC];
         end else if (prog_wr) begin
            o_flash_addr_q  <= OBL_POC_PRI;
            o_flash_wdata_q <= {7'h00, i_wdata[OBL_F_POC_MODE]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Decoded settings
   // ----------------------------------------------------------------
   // First and second byte fields.
   // Stable after fetch.
   // Outputs stay at their safe zero until the fetch has completed.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cfg_valid_q     <= 1'b0;
         o_lso_stoppable_q <= 1'b0;
         o_wdt_time_q      <= 3'h0;
         o_wdt_en_q        <= 1'b0;
         o_wdt_window_q    <= 2'h0;
         o_poc_dual_q      <= 1'b0;
      end else if (done_q) begin
         o_cfg_valid_q     <= 1'b1;
         o_lso_stoppable_q <= byte_q[OBL_IDX_WDT][OBL_F_LSO_STOP];
         o_wdt_time_q      <= byte_q[OBL_IDX_WDT][OBL_F_WDT_TM_HI:OBL_F_WDT_TM_LO];
         o_wdt_en_q        <= byte_q[OBL_IDX_WDT][OBL_F_WDT_EN];
         o_wdt_window_q    <= byte_q[OBL_IDX_WDT][OBL_F_WDT_WN_HI:OBL_F_WDT_WN_LO];
         o_poc_dual_q      <= byte_q[OBL_IDX_POC][OBL_F_POC_MODE];
      end
   end

   // Debug decode.
   // The prohibited code is treated as disabled, the safe reading.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_dbg_en_q    <= 1'b0;
         o_dbg_erase_q <= 1'b0;
      end else if (done_q) begin
         o_dbg_en_q    <= (dbg_code == OBL_DBG_KEEP) || (dbg_code == OBL_DBG_ERASE);
         o_dbg_erase_q <= (dbg_code == OBL_DBG_ERASE);
      end
   end

   // ----------------------------------------------------------------
   // Control and status
   // ----------------------------------------------------------------
   // The stop command is honoured only when the option byte allows it.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lso_req_q    <= 1'b0;
         o_lso_stop_q <= 1'b0;
      end else begin
         if (i_wr && (i_addr == OBL_REG_CTRL)) begin
            lso_req_q <= i_wdata[OBL_C_LSO_REQ];
         end
         o_lso_stop_q <= lso_req_q && o_lso_stoppable_q;
      end
   end

   // A new refusal in the same cycle as a clear keeps the flag set.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_rej_q <= 1'b0;
      end else if (rej_wr) begin
         wr_rej_q <= 1'b1;
      end else if (i_wr && (i_addr == OBL_REG_STAT) && i_wdata[OBL_S_WR_REJ]) begin
         wr_rej_q <= 1'b0;
      end
   end

   // Read data for one cycle after the strobe, zero otherwise and for unmapped addresses.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata_q <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            OBL_REG_WDT:  o_rdata_q <= byte_q[0];
            OBL_REG_POC:  o_rdata_q <= byte_q[1];
            OBL_REG_RSVA: o_rdata_q <= byte_q[2];
            OBL_REG_RSVB: o_rdata_q <= byte_q[3];
            OBL_REG_DBG:  o_rdata_q <= byte_q[4];
            OBL_REG_STAT: o_rdata_q <= {3'h0,
                                        (state_q != OBL_ST_DONE),
                                        wr_rej_q,
                                        done_q && (dbg_code == OBL_DBG_BAD),
                                        swap_q,
                                        done_q};
            OBL_REG_CTRL: o_rdata_q <= {7'h00, lso_req_q};
            default:      o_rdata_q <= 8'h00;
         endcase
      end else begin
         o_rdata_q <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Supply reset
   // ----------------------------------------------------------------
   logic hold_int;

   obl_supply_reset u_supply (
      .i_sys_clk      (i_sys_clk),
      .i_arst_n       (i_arst_n),
      .i_mode_dual    (o_poc_dual_q),
      .i_vdd_above_hi (i_vdd_above_hi),
      .i_vdd_above_lo (i_vdd_above_lo),
      .o_hold_q       (hold_int)
   );

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_supply_reset_q <= 1'b1;
      end else begin
         o_supply_reset_q <= hold_int;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);

   fetch_start_a: assert property (state_q == OBL_ST_START |=> ##1 o_flash_rd_q)
      else $error("fetch did not start after reset");

   swap_area_a: assert property (o_flash_rd_q |->
      (o_flash_addr_q[15:8] == (swap_q ? OBL_ALT_BASE[15:8] : OBL_PRI_BASE[15:8])))
      else $error("option byte read from wrong area");

   wdt_decode_a: assert property ($rose(done_q) |=>
      (o_wdt_en_q == byte_q[OBL_IDX_WDT][OBL_F_WDT_EN]) && o_cfg_valid_q)
      else $error("watchdog enable not decoded");

   poc_mode_a: assert property (done_q |=>
      o_poc_dual_q == $past(byte_q[OBL_IDX_POC][OBL_F_POC_MODE]))
      else $error("threshold mode mismatch");

   prog_guard_a: assert property ((i_wr && i_addr == OBL_REG_POC && !i_ext_prog)
      |=> !o_flash_wr_q ##1 wr_rej_q)
      else $error("mode write passed without programmer");

   copy_write_a: assert property (state_q == OBL_ST_COPY |=>
      o_flash_wr_q && (o_flash_addr_q == OBL_POC_PRI))
      else $error("boot swap copy not issued");

   dbg_decode_a: assert property (done_q && dbg_code == OBL_DBG_BAD |=>
      !o_dbg_en_q && !o_dbg_erase_q)
      else $error("prohibited debug code enabled debug");

   cfg_stable_a: assert property (o_cfg_valid_q |=>
      $stable(o_poc_dual_q) && $stable(o_dbg_en_q) && $stable(o_wdt_time_q) && o_cfg_valid_q)
      else $error("settings changed after fetch");

endmodule : obl_loader

`default_nettype wire

// ---- pkg/obl_pkg.sv ----
// Purpose: Shared constants and types for the option byte loader.
// Assumes: Flash byte addresses are 16 bits; register port addresses are 8 bits.
// Notes:   Every offset, field position and code used by more than one file lives here.

package obl_pkg;

   // ----------------------------------------------------------------
   // Flash option byte area
   // ----------------------------------------------------------------
   localparam logic [15:0] OBL_PRI_BASE    = 16'h0080;  // Primary option byte area.
   localparam logic [15:0] OBL_ALT_BASE    = 16'h1080;  // Alternate area used under boot swap.
   localparam logic [15:0] OBL_POC_PRI     = 16'h0081;  // Primary location of the mode byte.
   localparam logic [2:0]  OBL_NUM_BYTES   = 3'h5;      // Bytes fetched per load.
   localparam logic [2:0]  OBL_IDX_LAST    = 3'h4;      // Index of the last byte.
   localparam int          OBL_IDX_WDT     = 0;         // Oscillator and watchdog byte.
   localparam int          OBL_IDX_POC     = 1;         // Supply reset mode byte.
   localparam int          OBL_IDX_DBG     = 4;         // Debug control byte.
   localparam logic [7:0]  OBL_BYTE_RST    = 8'h00;     // Shadow byte value after reset.

   // ----------------------------------------------------------------
   // Register port map
   // ----------------------------------------------------------------
   localparam logic [7:0]  OBL_REG_WDT     = 8'h80;     // Oscillator and watchdog byte.
   localparam logic [7:0]  OBL_REG_POC     = 8'h81;     // power_on_clear_config_byte.
   localparam logic [7:0]  OBL_REG_RSVA    = 8'h82;     // reserved_option_byte_a.
   localparam logic [7:0]  OBL_REG_RSVB    = 8'h83;     // reserved_option_byte_b.
   localparam logic [7:0]  OBL_REG_DBG     = 8'h84;     // debug_control_byte.
   localparam logic [7:0]  OBL_REG_STAT    = 8'h90;     // Loader status.
   localparam logic [7:0]  OBL_REG_CTRL    = 8'h91;     // Loader control.

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int OBL_F_LSO_STOP  = 0;   // 1: software may stop the low-speed oscillator.
   localparam int OBL_F_WDT_TM_LO = 1;   // Watchdog overflow time, bits 3:1.
   localparam int OBL_F_WDT_TM_HI = 3;
   localparam int OBL_F_WDT_EN    = 4;   // Watchdog counter enable.
   localparam int OBL_F_WDT_WN_LO = 5;   // Watchdog window period, bits 6:5.
   localparam int OBL_F_WDT_WN_HI = 6;
   localparam int OBL_F_POC_MODE  = 0;   // reset_threshold_mode_select.
   localparam int OBL_F_DBG_LO    = 0;   // debug_enable_lo.
   localparam int OBL_F_DBG_HI    = 1;   // debug_enable_hi.
   localparam int OBL_S_DONE      = 0;   // Status: fetch complete.
   localparam int OBL_S_SWAP      = 1;   // Status: alternate area used.
   localparam int OBL_S_DBG_BAD   = 2;   // Status: prohibited debug code seen.
   localparam int OBL_S_WR_REJ    = 3;   // Status: mode write refused (write 1 clears).
   localparam int OBL_S_BUSY      = 4;   // Status: flash access in flight.
   localparam int OBL_C_LSO_REQ   = 0;   // Control: request low-speed oscillator stop.

   // ----------------------------------------------------------------
   // Codes and states
   // ----------------------------------------------------------------
   localparam logic [1:0]  OBL_DBG_OFF     = 2'h0;  // Debug disabled.
   localparam logic [1:0]  OBL_DBG_BAD     = 2'h1;  // Prohibited setting.
   localparam logic [1:0]  OBL_DBG_KEEP    = 2'h2;  // Enabled, flash kept on failed auth.
   localparam logic [1:0]  OBL_DBG_ERASE   = 2'h3;  // Enabled, flash erased on failed auth.

   typedef enum logic [2:0] {
      OBL_ST_START,
      OBL_ST_RD,
      OBL_ST_WAIT,
      OBL_ST_COPY,
      OBL_ST_COPY_WAIT,
      OBL_ST_PROG_WAIT,
      OBL_ST_DONE
   } obl_state_t;

endpackage : obl_pkg

// ---- rtl/obl_hold_reg.sv ----
// Purpose: One shadow byte register, loaded when the fetch delivers its byte.
// Assumes: Load is a one-cycle pulse from the loader.
// Notes:   Holds its value until the next reset so consumers see a steady setting.

`timescale 1ns/1ps
`default_nettype none

module obl_hold_reg #(
   parameter int         W   = 8,          // Data width.
   parameter logic [7:0] RST = 8'h00       // Reset value.
) (
   input  wire logic         i_sys_clk,    // System clock.
   input  wire logic         i_arst_n,     // Asynchronous reset, active low.
   input  wire logic         i_load,       // Capture strobe.
   input  wire logic [W-1:0] i_d,          // Byte from flash.
   output var  logic [W-1:0] o_q           // Held byte.
);

   // Capture on load only; no other path may disturb the held setting.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_q <= RST[W-1:0];
      end else if (i_load) begin
         o_q <= i_d;
      end
   end

endmodule : obl_hold_reg

`default_nettype wire

// ---- rtl/obl_supply_reset.sv ----
// Purpose: Supply reset hold logic with single or dual threshold behaviour.
// Assumes: Comparator levels arrive synchronous to the clock.
// Notes:   Before the mode is known the single threshold is used.

`timescale 1ns/1ps
`default_nettype none

module obl_supply_reset (
   input  wire logic i_sys_clk,      // System clock.
   input  wire logic i_arst_n,       // Asynchronous reset, active low.
   input  wire logic i_mode_dual,    // 1: dual threshold mode selected.
   input  wire logic i_vdd_above_hi, // Supply above upper threshold.
   input  wire logic i_vdd_above_lo, // Supply above lower threshold.
   output var  logic o_hold_q        // Reset hold request.
);

   logic released_q;  // Supply has cleared the release threshold.
   logic released_d;

   // Release needs the upper level in dual mode; the lower level always drops it.
   always_comb begin
      released_d = released_q;
      if (!i_vdd_above_lo) begin
         released_d = 1'b0;
      end else if (!released_q) begin
         released_d = i_mode_dual ? i_vdd_above_hi : 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         released_q <= 1'b0;
         o_hold_q   <= 1'b1;
      end else begin
         released_q <= released_d;
         o_hold_q   <= !released_d;
      end
   end

   lo_drop_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      !i_vdd_above_lo |=> o_hold_q)
      else $error("hold not raised below lower threshold");

   hi_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_mode_dual && !released_q && !i_vdd_above_hi) |=> o_hold_q)
      else $error("dual mode released below upper threshold");

endmodule : obl_supply_reset

`default_nettype wire

// ---- tb/obl_flash_model.sv ----
// Purpose: Behavioural flash array holding both option byte areas.
// Assumes: The loader keeps one access open at a time.
// Notes:   Between answers the data lines carry the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module obl_flash_model (
   input  wire logic        i_sys_clk, // System clock.
   input  wire logic        i_slow,    // 1: answer three cycles late.
   input  wire logic        i_rd,      // Read pulse.
   input  wire logic        i_wr,      // Write pulse.
   input  wire logic [15:0] i_addr,    // Byte address.
   input  wire logic [7:0]  i_wdata,   // Write data.
   output var  logic        o_ack,     // Access done pulse.
   output var  logic [7:0]  o_rdata    // Read data, valid with ack.
);
   logic [7:0] mem [logic [15:0]];
   int         wait_n = 0;
   logic [7:0] last = 8'h00;
   // --------
   // Answer
   // --------
   // Stale data must never look valid, so idle lines show a changed value.
   always @(posedge i_sys_clk) begin
      o_ack <= 1'b0;
      o_rdata <= ~last;
      if (i_wr) begin
         mem[i_addr] = i_wdata;
      end
      if ((i_rd || i_wr) && i_slow) begin
         wait_n <= 3;
      end else if ((i_rd || i_wr) || wait_n == 1) begin
         wait_n <= 0;
         o_ack <= 1'b1;
         o_rdata <= mem[i_addr];
         last <= mem[i_addr];
      end else if (wait_n > 1) begin
         wait_n <= wait_n - 1;
      end
   end
endmodule : obl_flash_model
`default_nettype wire

// ---- tb/test_obl_loader.sv ----
// Purpose: Self-checking bench for the option byte loader.
// Assumes: Flash model answers promptly or slowly on request.
// Notes:   Each boot re-runs the whole fetch from reset.
`timescale 1ns/1ps
`default_nettype none
module test_obl_loader;
   import obl_pkg::*;
   logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_boot_swap = 1'b0, i_ext_prog = 1'b0, slow = 1'b0;
   logic i_vdd_above_hi = 1'b1, i_vdd_above_lo = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_flash_ack;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, rd_val, i_flash_rdata, o_flash_wdata_q, o_rdata_q;
   logic [15:0] o_flash_addr_q;
   logic o_flash_rd_q, o_flash_wr_q, o_cfg_valid_q, o_lso_stoppable_q, o_lso_stop_q, o_wdt_en_q;
   logic o_poc_dual_q, o_dbg_en_q, o_dbg_erase_q, o_supply_reset_q;
   logic [2:0] o_wdt_time_q;
   logic [1:0] o_wdt_window_q;
   int miscompares = 0, samples_checked = 0, cyc = 0;
   obl_loader i_dut (.i_sys_clk, .i_arst_n, .i_boot_swap, .i_ext_prog, .i_vdd_above_hi,
      .i_vdd_above_lo, .o_flash_rd_q, .o_flash_wr_q, .o_flash_addr_q, .o_flash_wdata_q,
      .i_flash_ack, .i_flash_rdata, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata_q, .o_cfg_valid_q,
      .o_lso_stoppable_q, .o_lso_stop_q, .o_wdt_time_q, .o_wdt_en_q, .o_wdt_window_q,
      .o_poc_dual_q, .o_dbg_en_q, .o_dbg_erase_q, .o_supply_reset_q);
   obl_flash_model i_flash (.i_sys_clk, .i_slow(slow), .i_rd(o_flash_rd_q), .i_wr(o_flash_wr_q),
      .i_addr(o_flash_addr_q), .i_wdata(o_flash_wdata_q), .o_ack(i_flash_ack),
      .o_rdata(i_flash_rdata));
   // --------
   // Helpers
   // --------
   always #10 i_sys_clk = ~i_sys_clk;
   // A hung fetch ends the boot wait after 200 cycles; the run is also capped at 20000 cycles.
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 rd_val = o_rdata_q;
   endtask : rd
   task automatic boot(input logic sw, input logic s);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      i_arst_n <= 1'b0;
      i_boot_swap <= sw;
      slow <= s;
      repeat (10) @(posedge i_sys_clk);
      i_arst_n <= 1'b1;
      while (o_cfg_valid_q !== 1'b1 && n < 200) begin
         @(posedge i_sys_clk);
         n++;
      end
      chk(o_cfg_valid_q, 1'b1);
   endtask : boot
   task automatic sup(input logic hi, input logic lo, input logic exp);
      i_vdd_above_hi <= hi;
      i_vdd_above_lo <= lo;
      repeat (5) @(posedge i_sys_clk);
      chk(o_supply_reset_q, exp);
   endtask : sup
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   // --------
   // Tests
   // --------
   initial begin
      // programmed bytes keep reserved bits zero.
      for (int i = 0; i < 5; i++) begin
         i_flash.mem[OBL_PRI_BASE + 16'(i)] = 8'h00;
         i_flash.mem[OBL_ALT_BASE + 16'(i)] = 8'h00;
      end
      i_flash.mem[16'h0080] = 8'h55;
      i_flash.mem[16'h0081] = 8'h01;
      i_flash.mem[16'h0084] = 8'h03;
      i_flash.mem[16'h1080] = 8'h2a;
      i_flash.mem[16'h1084] = 8'h03;
      boot(1'b0, 1'b0);
      chk({o_wdt_window_q, o_wdt_en_q, o_wdt_time_q, o_lso_stoppable_q}, 7'h55);
      chk({o_poc_dual_q, o_dbg_en_q, o_dbg_erase_q}, 3'h7);
      for (int i = 0; i < 5; i++) begin
         rd(OBL_REG_WDT + 8'(i));
         chk(rd_val, i_flash.mem[OBL_PRI_BASE + 16'(i)]);
      end
      rd(8'ha0);
      chk(rd_val, 8'h00);
      wr(OBL_REG_POC, 8'h00);
      rd(OBL_REG_STAT);
      chk(rd_val, 8'h09);
      chk(i_flash.mem[OBL_POC_PRI], 8'h01);
      wr(OBL_REG_STAT, 8'h08);
      rd(OBL_REG_STAT);
      chk(rd_val, 8'h01);
      wr(OBL_REG_CTRL, 8'h01);
      repeat (3) @(posedge i_sys_clk);
      chk(o_lso_stop_q, 1'b1);
      i_ext_prog <= 1'b1;
      wr(OBL_REG_POC, 8'hfe);
      repeat (6) @(posedge i_sys_clk);
      chk(i_flash.mem[OBL_POC_PRI], 8'h00);
      chk(o_poc_dual_q, 1'b1);
      i_ext_prog <= 1'b0;
      sup(1'b0, 1'b1, 1'b0);
      sup(1'b0, 1'b0, 1'b1);
      sup(1'b0, 1'b1, 1'b1);
      sup(1'b1, 1'b1, 1'b0);
      $display("test primary fetch and registers done");
      i_flash.mem[OBL_POC_PRI] = 8'h01; // mode rewritten after a batch erase.
      boot(1'b1, 1'b1);
      chk({o_wdt_window_q, o_wdt_en_q, o_wdt_time_q, o_lso_stoppable_q}, 7'h2a);
      chk({o_poc_dual_q, o_dbg_en_q, o_dbg_erase_q}, 3'h3);
      chk(i_flash.mem[OBL_POC_PRI], 8'h00);
      rd(OBL_REG_STAT);
      chk(rd_val, 8'h03);
      wr(OBL_REG_CTRL, 8'h01);
      repeat (3) @(posedge i_sys_clk);
      chk(o_lso_stop_q, 1'b0);
      sup(1'b0, 1'b0, 1'b1);
      sup(1'b0, 1'b1, 1'b0);
      $display("test boot swap done");
      for (int c = 0; c < 4; c++) begin
         i_flash.mem[16'h0084] = 8'(c);
         i_flash.mem[OBL_POC_PRI] = {7'h00, c[0]};
         boot(1'b0, 1'b0);
         chk({o_poc_dual_q, o_dbg_en_q, o_dbg_erase_q}, {c[0], c[1], c == 3});
         rd(OBL_REG_STAT);
         chk(rd_val[2], c == 1);
      end
      $display("test debug codes done");
      summarize();
   end
endmodule : test_obl_loader
`default_nettype wire
